// ### core/rtfhf_pkg.sv
// constants, codes and carrier types shared by the telegram filter and host framer
// assumes a single clock domain; every byte code here is a wire-level value
package rtfhf_pkg;

  // ----------------------------------------------------------------
  // host packet framing codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RTFHF_SYNC_BYTE = 8'h55; // first byte of every packet
  localparam logic [7:0] RTFHF_OPT_LEN_RX = 8'h07; // optional bytes of a received frame
  localparam logic [7:0] RTFHF_OPT_LEN_NONE = 8'h00; // reply and event carry no optional data
  localparam logic [7:0] RTFHF_PTYPE_RX = 8'h01; // received_frame_packet
  localparam logic [7:0] RTFHF_PTYPE_RESP = 8'h02; // reply packet
  localparam logic [7:0] RTFHF_PTYPE_EVT = 8'h04; // event packet
  localparam logic [7:0] RTFHF_REPLY_SUCCESS = 8'h00; // reply_success return code
  localparam logic [7:0] RTFHF_TX_COMPLETE_EVENT = 8'h08; // transmit_complete_event code
  localparam logic [15:0] RTFHF_SHORT_DATA_LEN = 16'h0001; // one data byte in reply/event
  localparam logic [31:0] RTFHF_BROADCAST_ID = 32'hFFFFFFFF; // destination of broadcasts

  // ----------------------------------------------------------------
  // checksum
  // ----------------------------------------------------------------
  localparam logic [7:0] RTFHF_CRC_POLY = 8'h07; // x^8 + x^2 + x + 1
  localparam logic [7:0] RTFHF_CRC_INIT = 8'h00; // start value of both checksums

  // ----------------------------------------------------------------
  // filter codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RTFHF_FTYPE_SENDER = 8'h00; // sender_unique_id equals value
  localparam logic [7:0] RTFHF_FTYPE_CLASS = 8'h01; // telegram_class_code equals value lsb
  localparam logic [7:0] RTFHF_FTYPE_STRENGTH = 8'h02; // strength at or below -value dBm
  localparam logic [7:0] RTFHF_FTYPE_DEST = 8'h03; // destination id equals value
  localparam int RTFHF_ACT_POL_BIT = 7; // action bit: forward when condition true
  localparam int RTFHF_ACT_REP_BIT = 6; // action bit: repeat as well
  localparam logic [7:0] RTFHF_REP_MODE_SELECTIVE = 8'h02; // repeater_mode_select value

  // ----------------------------------------------------------------
  // security level codes carried through to the host
  // ----------------------------------------------------------------
  localparam logic [7:0] RTFHF_SEC_NONE = 8'h00; // not processed
  localparam logic [7:0] RTFHF_SEC_OBSOLETE = 8'h01; // old security concept
  localparam logic [7:0] RTFHF_SEC_DECRYPTED = 8'h02; // decrypted
  localparam logic [7:0] RTFHF_SEC_AUTH = 8'h03; // authenticated
  localparam logic [7:0] RTFHF_SEC_DEC_AUTH = 8'h04; // decrypted and authenticated

  // ----------------------------------------------------------------
  // byte positions inside the header and the optional field
  // ----------------------------------------------------------------
  localparam logic [2:0] RTFHF_HDR_SYNC = 3'h0;
  localparam logic [2:0] RTFHF_HDR_LEN_HI = 3'h1;
  localparam logic [2:0] RTFHF_HDR_LEN_LO = 3'h2;
  localparam logic [2:0] RTFHF_HDR_OPT_LEN = 3'h3;
  localparam logic [2:0] RTFHF_HDR_PTYPE = 3'h4;
  localparam logic [2:0] RTFHF_HDR_CRC = 3'h5;
  localparam logic [2:0] RTFHF_OPT_SUBF = 3'h0;
  localparam logic [2:0] RTFHF_OPT_DEST0 = 3'h1; // msb of destination id
  localparam logic [2:0] RTFHF_OPT_DEST1 = 3'h2;
  localparam logic [2:0] RTFHF_OPT_DEST2 = 3'h3;
  localparam logic [2:0] RTFHF_OPT_DEST3 = 3'h4; // lsb of destination id
  localparam logic [2:0] RTFHF_OPT_RSSI = 3'h5;
  localparam logic [2:0] RTFHF_OPT_SEC = 3'h6;
  localparam logic [2:0] RTFHF_IDX_RST = 3'h0; // index value after reset

  // ----------------------------------------------------------------
  // carrier types and state encodings
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] sender_unique_id; // sender of the telegram
    logic [7:0] telegram_class_code; // class code of the telegram
    logic [7:0] rssi_mag; // best strength, positive magnitude of dBm
    logic [31:0] dest_id; // addressed unique id
    logic broadcast; // telegram was broadcast
    logic [7:0] subframe_count; // subframes received
    logic [7:0] security_level; // one of the security codes
    logic [7:0] length; // payload bytes, checksum removed
  } rtfhf_tel_info_type;

  typedef struct packed {
    logic enable; // entry is in use
    logic [7:0] ftype; // filter type code
    logic [31:0] value; // compare value
    logic [7:0] action; // action code
  } rtfhf_filter_type;

  typedef struct packed {
    logic valid; // byte offered to the host link
    logic last; // final byte of a packet
    logic [7:0] data; // byte value
  } rtfhf_host_byte_type;

  typedef enum logic [4:0] {
    RTFHF_ST_IDLE = 5'h01,
    RTFHF_ST_HDR = 5'h02,
    RTFHF_ST_DATA = 5'h04,
    RTFHF_ST_OPT = 5'h08,
    RTFHF_ST_CRCD = 5'h10
  } rtfhf_state_type;

  typedef enum logic [2:0] {
    RTFHF_KIND_RX = 3'h1,
    RTFHF_KIND_RESP = 3'h2,
    RTFHF_KIND_EVT = 3'h4
  } rtfhf_kind_type;

endpackage : rtfhf_pkg

// ### core/rtfhf_crc8.sv
// one-byte step of the packet checksum, purely combinational
// assumes the caller registers the result; no state is held here
`timescale 1ns/1ns
module rtfhf_crc8
  import rtfhf_pkg::*;
(
  input wire logic [7:0] i_crc,
  input wire logic [7:0] i_byte,
  output logic [7:0] o_crc
);

  // ----------------------------------------------------------------
  // bitwise msb-first division, unrolled by the loop
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] acc;
    acc = i_crc ^ i_byte;
    for (int b = 0; b < 8; b++) begin
      // shift out the msb and fold in the polynomial when it was set
      acc = acc[7] ? ({acc[6:0], 1'b0} ^ RTFHF_CRC_POLY) : {acc[6:0], 1'b0};
    end
    o_crc = acc;
  end

endmodule : rtfhf_crc8

// ### core/rtfhf_framer.sv
// received telegram filter, repeat selector and host packet framer
// assumes telegrams arrive whole with their info, host link is a byte stream
// with valid/ready on the module clock, and the radio reports transmit done
//
// Contract
// R01 - type 0x00: sender id equals value
// R02 - type 0x01: class code equals value lsb
// R03 - type 0x02: strength at or below -value dBm
// R04 - action 0x00: forward only when condition false
// R05 - action 0x80: forward only when condition true
// R06 - action 0xC0: forward and repeat when true
// R07 - action 0x40: forward and repeat when false
// R08 - never repeat without also forwarding
// R09 - selective repeat only in repeater mode 0x02
// R10 - header: sync, length, optlen 7, type 1
// R11 - telegram payload from offset 6, checksum removed
// R12 - subframe count byte, zero without maturity wait
// R13 - four-byte destination, all-ones when broadcast
// R14 - best strength byte as positive magnitude
// R15 - security level byte with defined codes
// R16 - trailing checksum over data and optional data
// R17 - valid transmit request answered with success reply
// R18 - completion event 0x08 after radio transmit
// R19 - host waits 40 ms or event before power-down
// R20 - header checksum over length, optlen, type
`timescale 1ns/1ns
module rtfhf_framer
  import rtfhf_pkg::*;
#(
  parameter int NUM_FILTERS = 4, // filter entries evaluated in parallel
  parameter int MAX_TEL_LEN = 32 // longest payload held, in bytes
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_tel_valid,
  output logic o_tel_ready,
  input wire rtfhf_tel_info_type i_tel_info,
  input wire logic [MAX_TEL_LEN-1:0][7:0] i_tel_payload,
  input wire rtfhf_filter_type [NUM_FILTERS-1:0] i_filters,
  input wire logic [7:0] i_repeater_mode_select,
  input wire logic i_wait_maturity,
  output logic o_repeat_req,
  input wire logic i_tx_req,
  input wire logic i_tx_format_ok,
  output logic o_radio_tx_start,
  input wire logic i_radio_tx_done,
  output rtfhf_host_byte_type o_host,
  input wire logic i_host_ready
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int IDXW = (MAX_TEL_LEN > 1) ? $clog2(MAX_TEL_LEN) : 1;
  localparam logic [7:0] MAX_LEN8 = 8'(MAX_TEL_LEN);

  initial begin
    // the length field is one byte wide and indexing needs two entries
    if (MAX_TEL_LEN < 2 || MAX_TEL_LEN > 255) begin
      $error("MAX_TEL_LEN must lie in 2..255");
    end
    if (NUM_FILTERS < 1) begin
      $error("NUM_FILTERS must be at least 1");
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtfhf_state_type state_ff, nxt_state; // framer sequence
  rtfhf_kind_type kind_ff, nxt_kind; // packet being framed
  logic [2:0] idx_ff, nxt_idx; // header / optional byte position
  logic [7:0] data_idx_ff, nxt_data_idx; // payload byte position
  logic [7:0] crc_ff, nxt_crc; // running checksum
  rtfhf_tel_info_type tel_ff, nxt_tel; // held telegram info
  logic [MAX_TEL_LEN-1:0][7:0] pay_ff, nxt_pay; // held payload
  logic resp_pend_ff, nxt_resp_pend; // reply owed to host
  logic evt_pend_ff, nxt_evt_pend; // completion event owed
  logic tel_ready_ff, nxt_tel_ready; // telegram intake open
  logic repeat_ff, nxt_repeat; // repeat request pulse
  logic tx_start_ff, nxt_tx_start; // radio start pulse
  rtfhf_host_byte_type host_ff, nxt_host; // byte on the host link

  // ----------------------------------------------------------------
  // helper signals
  // ----------------------------------------------------------------
  logic fil_fwd_all; // every enabled entry lets it through
  logic fil_rep_any; // some enabled entry asks to repeat
  logic fil_cond; // condition of the entry being looked at
  logic fil_pass; // that entry's forward verdict
  logic [31:0] dest_eff; // destination as seen by the host
  logic [7:0] tel_len; // payload length clamped to the store
  logic adv; // host link can take a new byte
  logic emit; // a byte goes out this step
  logic [7:0] emit_byte; // its value
  logic emit_last; // it closes the packet
  logic crc_take; // fold the byte into the checksum
  logic crc_clear; // restart the checksum
  logic [7:0] crc_step; // checksum after folding emit_byte
  logic [15:0] hdr_len; // data length field
  logic [7:0] hdr_optlen; // optional length field
  logic [7:0] hdr_ptype; // packet type field
  logic tel_accept; // telegram taken this cycle
  logic tx_accept; // well-formed transmit request taken

  assign adv = !host_ff.valid || i_host_ready;
  assign tel_accept = i_tel_valid && tel_ready_ff;
  assign tx_accept = i_tx_req && i_tx_format_ok; // [R17]
  assign tel_len = (i_tel_info.length > MAX_LEN8) ? MAX_LEN8 : i_tel_info.length;
  assign dest_eff = i_tel_info.broadcast ? RTFHF_BROADCAST_ID : i_tel_info.dest_id;

  // ----------------------------------------------------------------
  // filter evaluation on the incoming telegram
  // ----------------------------------------------------------------
  // entries combine by and for forwarding, so any entry can veto a telegram;
  // with no entry enabled everything is forwarded and nothing repeated
  always_comb begin
    fil_fwd_all = 1'b1;
    fil_rep_any = 1'b0;
    fil_cond = 1'b0;
    fil_pass = 1'b0;
    for (int f = 0; f < NUM_FILTERS; f++) begin
      unique case (i_filters[f].ftype)
        // sender id matches the whole value [R01], class code its lsb [R02]
        RTFHF_FTYPE_SENDER: fil_cond = (i_tel_info.sender_unique_id == i_filters[f].value);
        RTFHF_FTYPE_CLASS: fil_cond = (i_tel_info.telegram_class_code == i_filters[f].value[7:0]);
        // larger magnitude is a weaker signal, so at-or-below means >= [R03]
        RTFHF_FTYPE_STRENGTH: fil_cond = (i_tel_info.rssi_mag >= i_filters[f].value[7:0]);
        RTFHF_FTYPE_DEST: fil_cond = (dest_eff == i_filters[f].value);
        default: fil_cond = 1'b0; // unknown type never matches
      endcase
      // polarity bit picks forward-on-true or forward-on-false [R04] [R05]
      fil_pass = (fil_cond == i_filters[f].action[RTFHF_ACT_POL_BIT]);
      if (i_filters[f].enable) begin
        fil_fwd_all = fil_fwd_all && fil_pass;
        // repeat only on the same verdict that forwards [R06] [R07] [R08]
        fil_rep_any = fil_rep_any || (fil_pass && i_filters[f].action[RTFHF_ACT_REP_BIT]);
      end
    end
  end

  // ----------------------------------------------------------------
  // header fields per packet kind
  // ----------------------------------------------------------------
  always_comb begin
    hdr_len = RTFHF_SHORT_DATA_LEN;
    hdr_optlen = RTFHF_OPT_LEN_NONE;
    hdr_ptype = RTFHF_PTYPE_RESP;
    unique case (kind_ff)
      RTFHF_KIND_RX: begin
        hdr_len = {8'h00, tel_ff.length}; // [R10]
        hdr_optlen = RTFHF_OPT_LEN_RX; // [R10]
        hdr_ptype = RTFHF_PTYPE_RX; // [R10]
      end
      RTFHF_KIND_RESP: hdr_ptype = RTFHF_PTYPE_RESP;
      RTFHF_KIND_EVT: hdr_ptype = RTFHF_PTYPE_EVT;
      default: hdr_ptype = RTFHF_PTYPE_RESP; // kind is one-hot, others illegal
    endcase
  end

  // ----------------------------------------------------------------
  // checksum step
  // ----------------------------------------------------------------
  rtfhf_crc8 u_crc8 (
    .i_crc(crc_ff),
    .i_byte(emit_byte),
    .o_crc(crc_step)
  );

  // ----------------------------------------------------------------
  // framer sequence: next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_idx = idx_ff;
    nxt_data_idx = data_idx_ff;
    nxt_tel = tel_ff;
    nxt_pay = pay_ff;
    nxt_repeat = 1'b0;
    nxt_tx_start = tx_accept;
    emit = 1'b0;
    emit_byte = 8'h00;
    emit_last = 1'b0;
    crc_take = 1'b0;
    crc_clear = 1'b0;
    // set wins over clear: a request in the start cycle stays owed
    nxt_resp_pend = resp_pend_ff || tx_accept;
    nxt_evt_pend = evt_pend_ff || i_radio_tx_done; // [R18]
    unique case (state_ff)
      RTFHF_ST_IDLE: begin
        // a telegram only arrives while nothing is owed, so it goes first;
        // replies outrank events so a completion never precedes its reply
        if (tel_accept) begin
          nxt_tel = i_tel_info;
          nxt_tel.length = tel_len;
          nxt_pay = i_tel_payload;
          if (fil_fwd_all) begin
            nxt_state = RTFHF_ST_HDR;
            nxt_kind = RTFHF_KIND_RX;
            nxt_idx = RTFHF_HDR_SYNC;
            // filter-driven repeat needs selective repeater mode [R09]
            nxt_repeat = fil_rep_any && (i_repeater_mode_select == RTFHF_REP_MODE_SELECTIVE);
          end
        end else if (resp_pend_ff) begin
          nxt_state = RTFHF_ST_HDR;
          nxt_kind = RTFHF_KIND_RESP;
          nxt_idx = RTFHF_HDR_SYNC;
          nxt_resp_pend = tx_accept;
        end else if (evt_pend_ff) begin
          nxt_state = RTFHF_ST_HDR;
          nxt_kind = RTFHF_KIND_EVT;
          nxt_idx = RTFHF_HDR_SYNC;
          nxt_evt_pend = i_radio_tx_done;
        end
      end
      RTFHF_ST_HDR: begin
        if (adv) begin
          emit = 1'b1;
          nxt_idx = idx_ff + 3'h1;
          unique case (idx_ff)
            RTFHF_HDR_SYNC: begin
              emit_byte = RTFHF_SYNC_BYTE; // [R10]
              crc_clear = 1'b1;
            end
            RTFHF_HDR_LEN_HI: begin
              emit_byte = hdr_len[15:8];
              crc_take = 1'b1; // [R20]
            end
            RTFHF_HDR_LEN_LO: begin
              emit_byte = hdr_len[7:0];
              crc_take = 1'b1; // [R20]
            end
            RTFHF_HDR_OPT_LEN: begin
              emit_byte = hdr_optlen;
              crc_take = 1'b1; // [R20]
            end
            RTFHF_HDR_PTYPE: begin
              emit_byte = hdr_ptype;
              crc_take = 1'b1; // [R20]
            end
            default: begin
              emit_byte = crc_ff; // header checksum, then restart for data [R20]
              crc_clear = 1'b1;
              nxt_data_idx = 8'h00;
              nxt_idx = RTFHF_OPT_SUBF;
              // an empty telegram skips straight to its optional data
              nxt_state = (kind_ff == RTFHF_KIND_RX && tel_ff.length == 8'h00) ?
                          RTFHF_ST_OPT : RTFHF_ST_DATA;
            end
          endcase
        end
      end
      RTFHF_ST_DATA: begin
        if (adv) begin
          emit = 1'b1;
          crc_take = 1'b1; // [R16]
          nxt_data_idx = data_idx_ff + 8'h01;
          unique case (kind_ff)
            RTFHF_KIND_RX: begin
              emit_byte = pay_ff[data_idx_ff[IDXW-1:0]]; // [R11]
              if (data_idx_ff == tel_ff.length - 8'h01) begin
                nxt_state = RTFHF_ST_OPT;
              end
            end
            RTFHF_KIND_RESP: begin
              emit_byte = RTFHF_REPLY_SUCCESS; // [R17]
              nxt_state = RTFHF_ST_CRCD;
            end
            default: begin
              emit_byte = RTFHF_TX_COMPLETE_EVENT; // [R18]
              nxt_state = RTFHF_ST_CRCD;
            end
          endcase
        end
      end
      RTFHF_ST_OPT: begin
        if (adv) begin
          emit = 1'b1;
          crc_take = 1'b1; // [R16]
          nxt_idx = idx_ff + 3'h1;
          unique case (idx_ff)
            RTFHF_OPT_SUBF: emit_byte = i_wait_maturity ? tel_ff.subframe_count : 8'h00; // [R12]
            RTFHF_OPT_DEST0: emit_byte = tel_ff.broadcast ? 8'hFF : tel_ff.dest_id[31:24]; // [R13]
            RTFHF_OPT_DEST1: emit_byte = tel_ff.broadcast ? 8'hFF : tel_ff.dest_id[23:16]; // [R13]
            RTFHF_OPT_DEST2: emit_byte = tel_ff.broadcast ? 8'hFF : tel_ff.dest_id[15:8]; // [R13]
            RTFHF_OPT_DEST3: emit_byte = tel_ff.broadcast ? 8'hFF : tel_ff.dest_id[7:0]; // [R13]
            RTFHF_OPT_RSSI: emit_byte = tel_ff.rssi_mag; // [R14]
            default: begin
              emit_byte = tel_ff.security_level; // passed through unchanged [R15]
              nxt_state = RTFHF_ST_CRCD;
            end
          endcase
        end
      end
      RTFHF_ST_CRCD: begin
        if (adv) begin
          emit = 1'b1;
          emit_byte = crc_ff; // data checksum closes the packet [R16]
          emit_last = 1'b1;
          nxt_state = RTFHF_ST_IDLE;
        end
      end
      default: nxt_state = RTFHF_ST_IDLE; // illegal code recovers to idle
    endcase
    // checksum bookkeeping
    nxt_crc = crc_clear ? RTFHF_CRC_INIT : (crc_take ? crc_step : crc_ff);
    // output byte holds until the host takes it
    nxt_host = host_ff;
    if (adv) begin
      nxt_host.valid = emit;
      nxt_host.last = emit_last;
      nxt_host.data = emit_byte;
    end
    // intake opens only when idle and nothing is owed to the host
    nxt_tel_ready = (nxt_state == RTFHF_ST_IDLE) && !nxt_resp_pend && !nxt_evt_pend;
  end

  // ----------------------------------------------------------------
  // framer sequence: registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= RTFHF_ST_IDLE;
      kind_ff <= RTFHF_KIND_RX;
      idx_ff <= RTFHF_IDX_RST;
      data_idx_ff <= 8'h00;
      crc_ff <= RTFHF_CRC_INIT;
      tel_ff <= '0;
      pay_ff <= '0;
      resp_pend_ff <= 1'b0;
      evt_pend_ff <= 1'b0;
      tel_ready_ff <= 1'b0;
      repeat_ff <= 1'b0;
      tx_start_ff <= 1'b0;
      host_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      idx_ff <= nxt_idx;
      data_idx_ff <= nxt_data_idx;
      crc_ff <= nxt_crc;
      tel_ff <= nxt_tel;
      pay_ff <= nxt_pay;
      resp_pend_ff <= nxt_resp_pend;
      evt_pend_ff <= nxt_evt_pend;
      tel_ready_ff <= nxt_tel_ready;
      repeat_ff <= nxt_repeat;
      tx_start_ff <= nxt_tx_start;
      host_ff <= nxt_host;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign o_tel_ready = tel_ready_ff;
  assign o_repeat_req = repeat_ff;
  assign o_radio_tx_start = tx_start_ff;
  assign o_host = host_ff;

endmodule : rtfhf_framer

// ### tb/rtfhf_props.sv
// checker for the telegram filter and host framer ports
// assumes bind onto rtfhf_framer, one clock, reset active high
`timescale 1ns/1ns
module rtfhf_props
  import rtfhf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_tel_valid,
  input wire logic o_tel_ready,
  input wire logic [7:0] i_repeater_mode_select,
  input wire logic o_repeat_req,
  input wire logic i_tx_req,
  input wire logic i_tx_format_ok,
  input wire logic o_radio_tx_start,
  input wire rtfhf_host_byte_type o_host,
  input wire logic i_host_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // accepted transmit request and a stalled host byte
  sequence s_tx_ok; i_tx_req && i_tx_format_ok; endsequence
  sequence s_stall; o_host.valid && !i_host_ready; endsequence
  a_tx_start: assert property (s_tx_ok |=> o_radio_tx_start)
    else $error("no radio start after request");
  a_tx_no_start: assert property (!(i_tx_req && i_tx_format_ok) |=> !o_radio_tx_start)
    else $error("radio start without request");
  a_host_hold: assert property (s_stall |=> o_host.valid && $stable(o_host.data))
    else $error("host byte changed while stalled");
  a_sync_first: assert property ($rose(o_host.valid) |-> o_host.data == 8'h55)
    else $error("packet does not open with sync");
  a_after_last: assert property (o_host.valid && o_host.last && i_host_ready
    |=> !o_host.valid || o_host.data == 8'h55)
    else $error("no sync after last byte");
  // repeat follows a take made while selective mode was set
  a_rep_cause: assert property (o_repeat_req |-> $past(i_tel_valid) && $past(o_tel_ready)
    && $past(i_repeater_mode_select) == 8'h02)
    else $error("repeat without selective take");
  a_rep_fwd: assert property (o_repeat_req |-> !o_tel_ready)
    else $error("repeat without forwarding");
  a_rep_pulse: assert property (o_repeat_req |=> !o_repeat_req)
    else $error("repeat request longer than one cycle");
endmodule : rtfhf_props
bind rtfhf_framer rtfhf_props chk_u (.i_clk, .i_sys_rst, .i_tel_valid, .o_tel_ready,
  .i_repeater_mode_select, .o_repeat_req, .i_tx_req, .i_tx_format_ok, .o_radio_tx_start,
  .o_host, .i_host_ready);

// ### tb/rtfhf_host_model.sv
// host model: takes framed bytes and keeps them in arrival order
// assumes a valid/ready byte link on the module clock
`timescale 1ns/1ns
module rtfhf_host_model
  import rtfhf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_slow,
  input wire rtfhf_host_byte_type i_host,
  output logic o_ready
);
  logic [7:0] got[$]; // bytes taken so far
  logic tog_ff = 1'b0; // slow mode: ready every other cycle, to stall the framer
  assign o_ready = !i_slow || tog_ff;
  always @(posedge i_clk) begin
    tog_ff <= !tog_ff;
    if (i_host.valid && o_ready) got.push_back(i_host.data);
  end
endmodule : rtfhf_host_model

// ### tb/tb_top.sv
// self-checking bench for the telegram filter and host framer
// assumes the host model collects every byte the framer hands over
`timescale 1ns/1ns
module tb_top;
  import rtfhf_pkg::*;
  localparam logic [31:0] S = 32'h12345678; // sender id under test
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_tel_valid = 1'b0, i_wait_maturity = 1'b0;
  logic i_tx_req = 1'b0, i_tx_format_ok = 1'b0, i_radio_tx_done = 1'b0, slow = 1'b0;
  logic o_tel_ready, o_repeat_req, o_radio_tx_start, host_ready, rep_seen = 1'b0;
  logic [7:0] mode = 8'h00;
  rtfhf_tel_info_type info = '0;
  logic [31:0][7:0] pay;
  rtfhf_filter_type [3:0] flt = '0;
  rtfhf_host_byte_type host;
  logic [7:0] exp[$], dq[$], oq[$];
  int n_errors = 0, n_compared = 0, k = 0, starts = 0;
  initial forever #20 i_clk = !i_clk;
  rtfhf_framer dut_u (.i_clk, .i_sys_rst, .i_tel_valid, .o_tel_ready, .i_tel_info(info),
    .i_tel_payload(pay), .i_filters(flt), .i_repeater_mode_select(mode), .i_wait_maturity,
    .o_repeat_req, .i_tx_req, .i_tx_format_ok, .o_radio_tx_start, .i_radio_tx_done,
    .o_host(host), .i_host_ready(host_ready));
  rtfhf_host_model host_u (.i_clk, .i_slow(slow), .i_host(host), .o_ready(host_ready));
  // pulse records; repeat flag restarts at each take
  always @(posedge i_clk) begin
    rep_seen <= o_repeat_req || (rep_seen && !(i_tel_valid && o_tel_ready));
    if (o_radio_tx_start) starts <= starts + 1;
  end
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : tick
  task automatic wait_ready();
    int n = 0;
    while (!o_tel_ready && n < 500) begin
      tick(1);
      n++;
    end
  endtask : wait_ready
  // append a packet from dq and oq to the expected stream
  task automatic add_pkt(input logic [7:0] pt);
    logic [7:0] h[$];
    logic [7:0] c;
    h = {8'h00, 8'(dq.size()), 8'(oq.size()), pt};
    c = 8'h00;
    foreach (h[i]) c = crc(c, h[i]);
    h = {8'h55, h, c};
    c = 8'h00;
    foreach (dq[i]) c = crc(c, dq[i]);
    foreach (oq[i]) c = crc(c, oq[i]);
    exp = {exp, h, dq, oq, c};
  endtask : add_pkt
  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %0t flag %b, want %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic chk_pkt();
    logic bad;
    bad = host_u.got.size() != exp.size();
    foreach (exp[i]) if (!bad && host_u.got[i] !== exp[i]) bad = 1'b1;
    n_compared++;
    if (bad) begin
      n_errors++;
      $display("unexpected %0t host bytes differ", $time);
    end
    host_u.got.delete();
    exp.delete();
  endtask : chk_pkt
  // one telegram through filter entry 0; length, broadcast, security vary with k
  task automatic run(input logic [7:0] ft, input logic [31:0] v, input logic [7:0] act,
    input logic [7:0] md, input logic [31:0] snd, input logic [7:0] cls,
    input logic [7:0] rs, input logic fwd, input logic rep);
    logic [31:0] d;
    flt[0] = {1'b1, ft, v, act};
    mode = md;
    slow = k[2];
    i_wait_maturity = k[1];
    info = {snd, cls, rs, 32'h0A0B0C0D, k[0], 8'h03, 8'((k + 2) % 7 % 5), 8'(k % 4)};
    i_tel_valid = 1'b1;
    wait_ready();
    tick(1);
    i_tel_valid = 1'b0;
    tick(30);
    wait_ready();
    tick(2);
    chk_bit(rep_seen, rep);
    dq.delete();
    if (fwd) begin
      for (int i = 0; i < k % 4; i++) dq.push_back(pay[i]);
      d = k[0] ? 32'hFFFFFFFF : 32'h0A0B0C0D;
      oq = {(k[1] ? 8'h03 : 8'h00), d[31:24], d[23:16], d[15:8], d[7:0], rs, info[15:8]};
      add_pkt(8'h01);
    end
    chk_pkt();
    k++;
  endtask : run
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    foreach (pay[i]) pay[i] = 8'(8'hC1 + 3 * i);
    tick(5);
    i_sys_rst = 1'b0;
    tick(2);
    run(8'h00, S, 8'h00, 8'h00, S, 8'hA5, 8'h3C, 0, 0);
    run(8'h00, S, 8'h00, 8'h00, 32'h1, 8'hA5, 8'h3C, 1, 0);
    run(8'h00, S, 8'h80, 8'h00, S, 8'hA5, 8'h3C, 1, 0);
    run(8'h01, 32'hA5, 8'h80, 8'h00, 32'h1, 8'hA5, 8'h3C, 1, 0);
    run(8'h01, 32'hA5, 8'h80, 8'h00, 32'h1, 8'hD2, 8'h3C, 0, 0);
    run(8'h02, 32'h46, 8'h00, 8'h00, 32'h1, 8'hA5, 8'h46, 0, 0);
    run(8'h02, 32'h46, 8'h00, 8'h00, 32'h1, 8'hA5, 8'h45, 1, 0);
    run(8'h00, S, 8'hC0, 8'h02, S, 8'hA5, 8'h3C, 1, 1);
    run(8'h00, S, 8'hC0, 8'h01, S, 8'hA5, 8'h3C, 1, 0);
    run(8'h01, 32'hA5, 8'h40, 8'h02, 32'h1, 8'hD2, 8'h3C, 1, 1);
    run(8'h01, 32'hA5, 8'h40, 8'h02, 32'h1, 8'hA5, 8'h3C, 0, 0);
    run(8'h03, 32'hFFFFFFFF, 8'h80, 8'h00, 32'h1, 8'hA5, 8'h3C, 1, 0);
    // malformed request ignored, then request and radio done together
    i_tx_req = 1'b1;
    tick(1);
    i_tx_req = 1'b0;
    tick(20);
    chk_bit(starts == 0, 1'b1);
    chk_pkt();
    slow = 1'b1;
    {i_tx_req, i_tx_format_ok, i_radio_tx_done} = 3'h7;
    tick(1);
    {i_tx_req, i_tx_format_ok, i_radio_tx_done} = 3'h0;
    tick(4);
    wait_ready();
    tick(2);
    chk_bit(starts == 1, 1'b1);
    dq = {8'h00};
    oq.delete();
    add_pkt(8'h02);
    dq = {8'h08};
    add_pkt(8'h04);
    chk_pkt();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    stop_test();
  end
endmodule : tb_top
